// file: hpmw_pkg.sv
/*
 * hpmw_pkg: constants and types of the halt / power-mode / wake-up controller.
 * Assumes a single 100 MHz system clock; slow oscillator ticks arrive as enables.
 */
package hpmw_pkg;

	// ==========================================================
	// register map (plain register port)
	// ==========================================================
	localparam logic [3:0] HPMW_ADDR_SYSCLK = 4'h0;
	localparam logic [3:0] HPMW_ADDR_FOSC   = 4'h1;
	localparam logic [3:0] HPMW_ADDR_WDOG   = 4'h2;
	localparam logic [3:0] HPMW_ADDR_STATUS = 4'h3;
	localparam logic [3:0] HPMW_ADDR_WAKE   = 4'h4;
	localparam logic [3:0] HPMW_ADDR_MODE   = 4'h5;

	// ==========================================================
	// field positions
	// ==========================================================
	localparam int HPMW_SYSCLK_SEL_LSB = 5;
	localparam int HPMW_SYSCLK_FKEEP   = 1;
	localparam int HPMW_SYSCLK_SKEEP   = 0;
	localparam int HPMW_FOSC_STABLE    = 1;
	localparam int HPMW_FOSC_EN        = 0;
	localparam int HPMW_WDOG_EN        = 3;
	localparam int HPMW_STAT_PDOWN     = 1;
	localparam int HPMW_STAT_TMO       = 0;

	// ==========================================================
	// reset values and the slow clock select code
	// ==========================================================
	localparam logic [2:0] HPMW_CKS_RST    = 3'h0;
	localparam logic [2:0] HPMW_CKS_SLOW   = 3'h7;
	localparam logic       HPMW_FOSC_EN_RST = 1'b1;
	localparam logic [2:0] HPMW_WS_RST     = 3'h3;
	localparam logic       HPMW_WDT_EN_RST = 1'b1;
	localparam logic [7:0] HPMW_WAKE_RST   = 8'h00;

	// ==========================================================
	// timing
	// ==========================================================
	localparam int HPMW_CLK_MHZ        = 100;
	localparam int HPMW_FOSC_START_US  = 16;
	localparam int HPMW_FOSC_START_CYC = HPMW_FOSC_START_US * HPMW_CLK_MHZ;
	localparam int HPMW_WDT_BASE_LOG2  = 8;
	localparam int HPMW_WDT_CNT_W      = 16;

	typedef enum logic [2:0] {
		HPMW_RUN        = 3'b000,
		HPMW_SLEEP      = 3'b001,
		HPMW_IDLE_SLOW  = 3'b010,
		HPMW_IDLE_BOTH  = 3'b011,
		HPMW_IDLE_FAST  = 3'b100,
		HPMW_WAKE_WAIT  = 3'b101
	} hpmw_state_t;

	// clock-gating outputs that travel together
	typedef struct packed {
		logic cpu_run;
		logic fast_clk_on;
		logic slow_clk_on;
		logic slow_osc_on;
	} hpmw_clk_en_t;

	// wake response to the core
	typedef struct packed {
		logic resume;
		logic take_irq;
		logic wdt_reset;
	} hpmw_wake_t;

endpackage : hpmw_pkg

// file: hpmw_sync.sv
/*
 * hpmw_sync: three-flop synchroniser, a change counts once stages two and
 * three agree. Assumes asynchronous inputs, one system clock.
 */
`timescale 1ns/100ps
module hpmw_sync #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         i_sys_clk,
	input  wire logic         i_rst,
	// data
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// idle-high pins, so resetting high avoids a false falling edge
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_q   <= '1;
			s2_q   <= '1;
			s3_q   <= '1;
			o_sync <= '1;
		end else begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int b = 0; b < W; b++) begin
				if (s2_q[b] == s3_q[b]) begin
					o_sync[b] <= s3_q[b];
				end
			end
		end
	end
endmodule : hpmw_sync

// file: hpmw_wdt.sv
/*
 * hpmw_wdt: watchdog counter on slow oscillator ticks, period 2^(8+ws).
 * Assumes i_tick is a one-cycle enable at the slow oscillator rate.
 */
`timescale 1ns/100ps
module hpmw_wdt
	import hpmw_pkg::*;
(
	// clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst,
	// control
	input  wire logic       i_tick,
	input  wire logic       i_enable,
	input  wire logic       i_clear,
	input  wire logic [2:0] i_period_sel,
	// status
	output logic            o_overflow
);
	logic [HPMW_WDT_CNT_W-1:0] cnt_q;
	logic [HPMW_WDT_CNT_W-1:0] limit;

	// RULE_20 code doubles division
	assign limit = HPMW_WDT_CNT_W'((32'd1 << (HPMW_WDT_BASE_LOG2 + 32'(i_period_sel))) - 32'd1);

	// RULE_09 clear then count or hold
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q      <= '0;
			o_overflow <= 1'b0;
		end else begin
			o_overflow <= 1'b0;
			if (i_clear) begin
				cnt_q <= '0;
			end else if (i_enable && i_tick) begin
				// RULE_17 slow ticks divided
				if (cnt_q >= limit) begin
					cnt_q      <= '0;
					o_overflow <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
		end
	end
endmodule : hpmw_wdt

// file: hpmw_ctrl.sv
/*
 * hpmw_ctrl: halt entry, power-mode selection, wake-up and oscillator control.
 * Assumes the core pulses halt / clear-watchdog and stalls while cpu_run is low;
 * slow oscillator ticks come as a one-cycle enable on the system clock.
 */
// Chosen here: the address map and the address-and-strobe port.
// Behaviour
// RULE_01: codes 000..110 pick fast clock divided by 1 to 64.
// RULE_02: fast oscillator restart is reported by a stable flag software polls.
// RULE_03: halt with both keep bits 0 enters sleep; only watchdog runs.
// RULE_04: halt with fast keep 0, slow keep 1 enters idle slow-only.
// RULE_05: halt with both keep bits 1 enters idle with both clocks.
// RULE_06: halt with fast keep 1, slow keep 0 enters idle fast-only.
// RULE_07: in any halt mode execution stops and state is held.
// RULE_08: halt entry sets power-down flag and clears timeout flag.
// RULE_09: halt clears watchdog counter; it counts on only if enabled.
// RULE_10: wake on enabled port A fall, interrupt, or watchdog overflow.
// RULE_11: power-down flag set by halt, cleared by reset or clear-watchdog.
// RULE_12: watchdog wake sets timeout flag, resets only PC and SP.
// RULE_13: per-pin wake enable; pin wake resumes after the halt.
// RULE_14: disabled irq or full stack: resume after halt, irq stays pending.
// RULE_15: enabled irq with free stack: normal interrupt response on wake.
// RULE_16: irq already pending at halt entry cannot wake the device.
// RULE_17: watchdog counts slow ticks divided by 2^8 to 2^15.
// RULE_18: clock select code 111 selects slow clock, slow mode.
// RULE_19: enabling fast oscillator clears stable flag until it settles.
// RULE_20: period code 000 is 2^8, each step doubles, 111 is 2^15.
// RULE_21: after wake, execution waits until selected oscillator is stable.
`timescale 1ns/100ps
module hpmw_ctrl
	import hpmw_pkg::*;
#(
	parameter int NPINS       = 8,
	parameter int NIRQ        = 4,
	parameter int START_CYC   = HPMW_FOSC_START_CYC
) (
	// clock and reset
	input  wire logic              i_sys_clk,
	input  wire logic              i_rst,
	// register port
	input  wire logic [3:0]        i_addr,
	input  wire logic [7:0]        i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [7:0]        o_rdata,
	// core events
	input  wire logic              i_halt,
	input  wire logic              i_clr_wdt,
	input  wire logic [NIRQ-1:0]   i_irq_req,
	input  wire logic [NIRQ-1:0]   i_irq_en,
	input  wire logic              i_stack_full,
	// pins and oscillator
	input  wire logic [NPINS-1:0]  i_porta,
	input  wire logic              i_slow_tick,
	// outputs to core and clock tree
	output hpmw_pkg::hpmw_clk_en_t o_clk_en,
	output hpmw_pkg::hpmw_wake_t   o_wake,
	output logic      [2:0]        o_sys_clk_select,
	output logic                   o_power_down_flag,
	output logic                   o_wdt_timeout_flag
);
	import hpmw_pkg::*;

	// ==========================================================
	// registers
	// ==========================================================
	logic [2:0]       cks_q;
	logic             fkeep_q;
	logic             skeep_q;
	logic             fosc_en_q;
	logic             fosc_stable_q;
	logic [2:0]       ws_q;
	logic             wdt_en_q;
	logic [NPINS-1:0] wake_en_q;
	logic             pdown_q;
	logic             tmo_q;
	hpmw_state_t      state_q;
	logic [NIRQ-1:0]  irq_mask_q;
	logic [NPINS-1:0] pin_prev_q;
	logic [$clog2(START_CYC+1)-1:0] start_cnt_q;
	logic             wake_wdt_q;
	logic             wake_irq_q;

	logic [NPINS-1:0] pin_s;
	logic             wdt_ovf;
	logic             halted;
	logic             pin_wake;
	logic             irq_wake;
	logic             fosc_running;
	logic             wdt_clear;

	assign halted   = (state_q != HPMW_RUN) && (state_q != HPMW_WAKE_WAIT);
	// RULE_13 per-pin falling edge
	assign pin_wake = |(pin_prev_q & ~pin_s & wake_en_q);
	// RULE_16 pre-pending irqs masked
	assign irq_wake = |(i_irq_req & ~irq_mask_q);
	assign wdt_clear = i_clr_wdt || (i_halt && state_q == HPMW_RUN);

	// fast oscillator is powered in run unless disabled, and kept in idle when asked
	always_comb begin
		fosc_running = fosc_en_q;
		if (halted) begin
			fosc_running = fosc_en_q && fkeep_q;
		end
	end

	// ==========================================================
	// submodules
	// ==========================================================
	hpmw_sync #(.W(NPINS)) u_sync (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_async   (i_porta),
		.o_sync    (pin_s)
	);

	hpmw_wdt u_wdt (
		.i_sys_clk    (i_sys_clk),
		.i_rst        (i_rst),
		.i_tick       (i_slow_tick),
		.i_enable     (wdt_en_q),
		.i_clear      (wdt_clear),
		.i_period_sel (ws_q),
		.o_overflow   (wdt_ovf)
	);

	// ==========================================================
	// register writes
	// ==========================================================
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			cks_q     <= HPMW_CKS_RST;
			fkeep_q   <= 1'b0;
			skeep_q   <= 1'b0;
			fosc_en_q <= HPMW_FOSC_EN_RST;
			ws_q      <= HPMW_WS_RST;
			wdt_en_q  <= HPMW_WDT_EN_RST;
			wake_en_q <= HPMW_WAKE_RST;
		end else if (i_wr) begin
			unique case (i_addr)
				HPMW_ADDR_SYSCLK: begin
					// RULE_01 fast divider select
					// RULE_18 code 111 is slow
					cks_q   <= i_wdata[HPMW_SYSCLK_SEL_LSB +: 3];
					fkeep_q <= i_wdata[HPMW_SYSCLK_FKEEP];
					skeep_q <= i_wdata[HPMW_SYSCLK_SKEEP];
				end
				HPMW_ADDR_FOSC: fosc_en_q <= i_wdata[HPMW_FOSC_EN];
				HPMW_ADDR_WDOG: begin
					wdt_en_q <= i_wdata[HPMW_WDOG_EN];
					ws_q     <= i_wdata[2:0];
				end
				HPMW_ADDR_WAKE: wake_en_q <= i_wdata[NPINS-1:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// read port, data one cycle after the strobe
	// ==========================================================
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= 8'h00;
			if (i_rd) begin
				unique case (i_addr)
					HPMW_ADDR_SYSCLK: o_rdata <= {cks_q, 3'h0, fkeep_q, skeep_q};
					// RULE_02 stable flag readable
					HPMW_ADDR_FOSC:   o_rdata <= {6'h00, fosc_stable_q, fosc_en_q};
					HPMW_ADDR_WDOG:   o_rdata <= {4'h0, wdt_en_q, ws_q};
					HPMW_ADDR_STATUS: o_rdata <= {6'h00, pdown_q, tmo_q};
					HPMW_ADDR_WAKE:   o_rdata <= 8'(wake_en_q);
					HPMW_ADDR_MODE:   o_rdata <= {5'h00, state_q};
					default:          o_rdata <= 8'h00;
				endcase
			end
		end
	end

	// ==========================================================
	// fast oscillator start-up
	// ==========================================================
	// RULE_19 stable only after start time
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			start_cnt_q   <= '0;
			fosc_stable_q <= 1'b0;
		end else if (!fosc_running) begin
			start_cnt_q   <= '0;
			fosc_stable_q <= 1'b0;
		end else if (!fosc_stable_q) begin
			if (32'(start_cnt_q) >= START_CYC - 1) begin
				fosc_stable_q <= 1'b1;
			end else begin
				start_cnt_q <= start_cnt_q + 1'b1;
			end
		end
	end

	// ==========================================================
	// power-mode state machine
	// ==========================================================
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q    <= HPMW_RUN;
			irq_mask_q <= '0;
			wake_wdt_q <= 1'b0;
			wake_irq_q <= 1'b0;
		end else begin
			unique case (state_q)
				HPMW_RUN: begin
					if (i_halt) begin
						// RULE_16 snapshot pending requests
						irq_mask_q <= i_irq_req;
						wake_wdt_q <= 1'b0;
						wake_irq_q <= 1'b0;
						// RULE_03 sleep
						// RULE_04 idle slow only
						// RULE_05 idle both clocks
						// RULE_06 idle fast only
						unique case ({fkeep_q, skeep_q})
							2'b00: state_q <= HPMW_SLEEP;
							2'b01: state_q <= HPMW_IDLE_SLOW;
							2'b11: state_q <= HPMW_IDLE_BOTH;
							2'b10: state_q <= HPMW_IDLE_FAST;
						endcase
					end
				end
				HPMW_SLEEP, HPMW_IDLE_SLOW, HPMW_IDLE_BOTH, HPMW_IDLE_FAST: begin
					// RULE_10 three wake sources
					if (pin_wake || irq_wake || wdt_ovf) begin
						state_q    <= HPMW_WAKE_WAIT;
						wake_wdt_q <= wdt_ovf;
						wake_irq_q <= irq_wake;
					end
				end
				HPMW_WAKE_WAIT: begin
					// RULE_21 wait for selected oscillator
					if (cks_q == HPMW_CKS_SLOW || fosc_stable_q) begin
						state_q <= HPMW_RUN;
					end
				end
				default: state_q <= HPMW_RUN;
			endcase
		end
	end

	// ==========================================================
	// status flags
	// ==========================================================
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			pdown_q <= 1'b0;
			tmo_q   <= 1'b0;
		end else begin
			// RULE_11 clear-watchdog clears, halt sets
			if (i_clr_wdt) begin
				pdown_q <= 1'b0;
			end
			// RULE_08 halt entry flags
			if (i_halt && state_q == HPMW_RUN) begin
				pdown_q <= 1'b1;
				tmo_q   <= 1'b0;
			end
			// RULE_12 watchdog wake sets timeout
			if (wdt_ovf && halted) begin
				tmo_q <= 1'b1;
			end
		end
	end

	// ==========================================================
	// outputs
	// ==========================================================
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_prev_q         <= '1;
			o_clk_en           <= '0;
			o_wake             <= '0;
			o_sys_clk_select   <= HPMW_CKS_RST;
			o_power_down_flag  <= 1'b0;
			o_wdt_timeout_flag <= 1'b0;
		end else begin
			pin_prev_q         <= pin_s;
			o_sys_clk_select   <= cks_q;
			o_power_down_flag  <= pdown_q;
			o_wdt_timeout_flag <= tmo_q;
			// RULE_07 cpu held while halted
			o_clk_en.cpu_run     <= (state_q == HPMW_RUN) && !i_halt;
			o_clk_en.fast_clk_on <= fosc_running && fosc_stable_q;
			o_clk_en.slow_clk_on <= !halted || skeep_q;
			// RULE_03 watchdog oscillator stays up
			o_clk_en.slow_osc_on <= !halted || skeep_q || wdt_en_q;
			o_wake <= '0;
			if (state_q == HPMW_WAKE_WAIT && (cks_q == HPMW_CKS_SLOW || fosc_stable_q)) begin
				// RULE_12 watchdog wake resets PC/SP
				o_wake.wdt_reset <= wake_wdt_q;
				// RULE_15 enabled irq with free stack
				// RULE_14 else resume after halt
				o_wake.take_irq  <= wake_irq_q && !i_stack_full &&
					|(i_irq_req & i_irq_en);
				o_wake.resume    <= 1'b1;
			end
		end
	end

endmodule : hpmw_ctrl

// file: hpmw_ctrl_properties.sv
/*
 * hpmw_ctrl_chk: port-level checks of the halt / wake controller.
 * Assumes the core pulses halt only while cpu_run is high.
 */
`timescale 1ns/100ps
module hpmw_ctrl_chk
	import hpmw_pkg::*;
#(
	parameter int NIRQ = 4
) (
	// clock and reset
	input wire logic                   i_sys_clk,
	input wire logic                   i_rst,
	// inputs watched
	input wire logic [3:0]             i_addr,
	input wire logic [7:0]             i_wdata,
	input wire logic                   i_wr,
	input wire logic                   i_halt,
	input wire logic                   i_clr_wdt,
	input wire logic [NIRQ-1:0]        i_irq_req,
	input wire logic [NIRQ-1:0]        i_irq_en,
	input wire logic                   i_stack_full,
	// outputs watched
	input wire hpmw_pkg::hpmw_clk_en_t o_clk_en,
	input wire hpmw_pkg::hpmw_wake_t   o_wake,
	input wire logic                   o_power_down_flag,
	input wire logic                   o_wdt_timeout_flag
);
	logic [1:0] keep_q;
	logic       live_q;
	logic       halt_ok;
	logic       irq_ok;

	assign halt_ok = i_halt && o_clk_en.cpu_run;
	assign irq_ok  = (|(i_irq_req & i_irq_en)) && !i_stack_full;

	// ==========================================
	// keep bits shadowed from register writes
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			keep_q <= 2'h0;
			live_q <= 1'b0;
		end else begin
			live_q <= 1'b1;
			if (i_wr && i_addr == HPMW_ADDR_SYSCLK) begin
				keep_q <= i_wdata[1:0];
			end
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	a_halt_stops_cpu: assert property (
		halt_ok |=> !o_clk_en.cpu_run [*2]) else $error("core ran on after halt");
	a_halt_flags: assert property (
		halt_ok |-> ##2 o_power_down_flag && !o_wdt_timeout_flag) else $error("halt flags wrong");
	a_pdf_clear: assert property (
		i_clr_wdt && !i_halt |-> ##2 !o_power_down_flag) else $error("power-down flag kept");
	a_pdf_cause: assert property (
		$rose(o_power_down_flag) |-> $past(halt_ok, 2)) else $error("power-down flag rose alone");
	a_halt_clocks: assert property (
		halt_ok |-> ##2 o_clk_en.slow_clk_on == keep_q[0] && (keep_q[1] || !o_clk_en.fast_clk_on))
		else $error("halt clock gating wrong");
	a_run_after_resume: assert property (
		$past(live_q) && $rose(o_clk_en.cpu_run) |-> $past(o_wake.resume)) else $error("early restart");
	a_resume_once: assert property (
		o_wake.resume |=> !o_wake.resume ##1 o_clk_en.cpu_run) else $error("resume pulse wrong");
	a_irq_taken: assert property (
		o_wake.take_irq |-> o_wake.resume && $past(irq_ok)) else $error("bad interrupt response");
	a_wdt_flags: assert property (
		o_wake.wdt_reset |-> o_wdt_timeout_flag && o_power_down_flag) else $error("watchdog flags");

	c_halt: cover property (halt_ok);
	c_irq: cover property (o_wake.take_irq);
	c_wdt: cover property (o_wake.wdt_reset);
endmodule : hpmw_ctrl_chk

bind hpmw_ctrl hpmw_ctrl_chk #(.NIRQ(NIRQ)) u_chk (.i_sys_clk, .i_rst, .i_addr, .i_wdata,
	.i_wr, .i_halt, .i_clr_wdt, .i_irq_req, .i_irq_en, .i_stack_full, .o_clk_en, .o_wake,
	.o_power_down_flag, .o_wdt_timeout_flag);

// file: hpmw_core_model.sv
/*
 * hpmw_core_model: stand-in core turning bench requests into halt and
 * clear-watchdog pulses. Assumes one-cycle requests from the bench.
 */
`timescale 1ns/100ps
module hpmw_core_model (
	// clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_rst,
	// requests and gate
	input  wire logic i_do_halt,
	input  wire logic i_do_clr,
	input  wire logic i_cpu_run,
	// instruction events
	output logic      o_halt,
	output logic      o_clr_wdt
);
	// gated core idle
	// a request made while gated is lost, as a stalled core fetches nothing
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_halt    <= 1'b0;
			o_clr_wdt <= 1'b0;
		end else begin
			o_halt    <= i_do_halt && i_cpu_run;
			o_clr_wdt <= i_do_clr && i_cpu_run;
		end
	end
endmodule : hpmw_core_model

// file: tb_top.sv
/*
 * tb_top: self-checking bench of the halt / wake controller.
 * Assumes a 100 MHz clock and a slow tick every second cycle.
 */
`timescale 1ns/100ps
module tb_top;
	import hpmw_pkg::*;
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
	$display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end

	logic         i_sys_clk, i_rst, i_wr, i_rd, i_stack_full, i_slow_tick;
	logic         i_halt, i_clr_wdt, do_halt, do_clr;
	logic [3:0]   i_addr, i_irq_req, i_irq_en, e;
	logic [7:0]   i_wdata, i_porta, o_rdata, d;
	logic [2:0]   o_sys_clk_select;
	logic [1:0]   m;
	logic         o_power_down_flag, o_wdt_timeout_flag;
	hpmw_clk_en_t o_clk_en;
	hpmw_wake_t   o_wake;
	int           error_cnt, checks_done, cycles, p, w;
	logic [11:0]  rst_tab [7] = '{12'h000, 12'h103, 12'h20B, 12'h300, 12'h400, 12'h500, 12'hF00};

	hpmw_ctrl #(.START_CYC(4)) dut (.i_sys_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata, .i_halt, .i_clr_wdt, .i_irq_req, .i_irq_en, .i_stack_full, .i_porta,
		.i_slow_tick, .o_clk_en, .o_wake, .o_sys_clk_select, .o_power_down_flag,
		.o_wdt_timeout_flag);
	hpmw_core_model u_core (.i_sys_clk, .i_rst, .i_do_halt(do_halt), .i_do_clr(do_clr),
		.i_cpu_run(o_clk_en.cpu_run), .o_halt(i_halt), .o_clr_wdt(i_clr_wdt));

	// ==========================================
	// clock, slow tick, hang guard
	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	always @(posedge i_sys_clk) begin
		i_slow_tick <= ~i_slow_tick;
		cycles++;
		if (cycles == 8000) begin
			error_cnt++;
			close_out();
		end
	end

	// ==========================================
	// tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		i_addr  <= a;
		i_wdata <= v;
		i_wr    <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask : rd
	// one core instruction: halt or clear-watchdog
	task automatic core(input logic h);
		do_halt <= h;
		do_clr  <= !h;
		@(posedge i_sys_clk);
		do_halt <= 1'b0;
		do_clr  <= 1'b0;
		cyc(2);
	endtask : core
	task automatic wait_wake(input int lim, input logic irq, input logic wdt);
		int n;
		n = 0;
		while (o_wake.resume !== 1'b1 && n < lim) begin
			cyc(1);
			n++;
		end
		`CHK(o_wake.resume, 1'b1)
		`CHK(o_wake.take_irq, irq)
		`CHK(o_wake.wdt_reset, wdt)
		cyc(2);
		`CHK(o_clk_en.cpu_run, 1'b1)
	endtask : wait_wake
	function automatic logic [7:0] mode_of(input logic [1:0] k);
		case (k)
			2'h0: return 8'h01;
			2'h1: return 8'h02;
			2'h3: return 8'h03;
			default: return 8'h04;
		endcase
	endfunction : mode_of
	task automatic close_out();
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out

	// ==========================================
	// main sequence
	initial begin
		void'($urandom(81632));
		{i_rst, i_wr, i_rd, i_stack_full, do_halt, do_clr, i_slow_tick} = 7'h40;
		{i_addr, i_wdata, i_irq_req, i_irq_en, i_porta} = 28'h00000FF;
		repeat (3) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		cyc(10);
		wr(4'hF, 8'hAA);
		foreach (rst_tab[k]) begin
			rd(rst_tab[k][11:8], d); `CHK(d, rst_tab[k][7:0])
		end
		wr(HPMW_ADDR_FOSC, 8'h00);
		wr(HPMW_ADDR_FOSC, 8'h01);
		rd(HPMW_ADDR_FOSC, d); `CHK(d, 8'h01)
		cyc(10);
		rd(HPMW_ADDR_FOSC, d); `CHK(d, 8'h03)
		for (int c = 7; c >= 0; c--) begin
			wr(HPMW_ADDR_SYSCLK, {3'(c), 5'h00});
			rd(HPMW_ADDR_SYSCLK, d); `CHK(d, {3'(c), 5'h00})
			`CHK(o_sys_clk_select, 3'(c))
		end
		// every halt mode, woken by a random enabled pin
		for (int k = 0; k < 4; k++) begin
			m = 2'(k ^ (k >> 1));
			p = $urandom_range(7);
			wr(HPMW_ADDR_SYSCLK, {3'($urandom_range(6)), 3'h0, m});
			wr(HPMW_ADDR_WAKE, 8'h01 << p);
			core(1'b1);
			rd(HPMW_ADDR_MODE, d); `CHK(d, mode_of(m))
			rd(HPMW_ADDR_STATUS, d); `CHK(d, 8'h02)
			`CHK(o_clk_en.slow_clk_on, m[0])
			`CHK(o_clk_en.fast_clk_on, m[1])
			`CHK(o_clk_en.slow_osc_on, 1'b1)
			i_porta <= ~(8'h01 << ((p + 1) % 8));
			cyc(10);
			`CHK(o_clk_en.cpu_run, 1'b0)
			i_porta <= ~((8'h01 << p) | (8'h01 << ((p + 1) % 8)));
			wait_wake(40, 1'b0, 1'b0);
			i_porta <= 8'hFF;
			cyc(2);
		end
		`CHK(o_power_down_flag, 1'b1)
		core(1'b0);
		`CHK(o_power_down_flag, 1'b0)
		// watchdog off, then interrupt wakes in all four cases
		wr(HPMW_ADDR_WAKE, 8'h00);
		wr(HPMW_ADDR_WDOG, 8'h00);
		core(1'b1);
		cyc(600);
		`CHK(o_clk_en.cpu_run, 1'b0)
		`CHK(o_clk_en.slow_osc_on, 1'b0)
		for (int k = 0; k < 4; k++) begin
			if (k > 0) core(1'b1);
			e = 4'h1 << $urandom_range(3);
			i_irq_en     <= k[0] ? e : 4'h0;
			i_stack_full <= k[1];
			i_irq_req    <= e;
			wait_wake(40, k == 1, 1'b0);
			{i_irq_req, i_irq_en, i_stack_full} <= 9'h000;
			cyc(2);
		end
		i_irq_req <= 4'h8;
		wr(HPMW_ADDR_WAKE, 8'h01);
		core(1'b1);
		cyc(20);
		`CHK(o_clk_en.cpu_run, 1'b0)
		i_porta <= 8'hFE;
		wait_wake(40, 1'b0, 1'b0);
		i_porta   <= 8'hFF;
		i_irq_req <= 4'h0;
		// watchdog overflow wake at 2^(8+ws) ticks
		w = $urandom_range(1);
		wr(HPMW_ADDR_WDOG, 8'h08 | 8'(w));
		wr(HPMW_ADDR_WAKE, 8'h00);
		core(1'b1);
		cyc(2 * (256 << w) - 40);
		`CHK(o_clk_en.cpu_run, 1'b0)
		wait_wake(80, 1'b0, 1'b1);
		rd(HPMW_ADDR_STATUS, d); `CHK(d, 8'h03)
		close_out();
	end
endmodule : tb_top
